// *** design/lmfc_sync_pkg.sv ***
`default_nettype none
package lmfc_sync_pkg;
  // Register offsets.
  localparam logic [11:0] ADDR_DUAL_SELECT   = 12'h008;
  localparam logic [11:0] ADDR_IRQ_EN_A      = 12'h021;
  localparam logic [11:0] ADDR_IRQ_EN_B      = 12'h022;
  localparam logic [11:0] ADDR_IRQ_ST_A      = 12'h025;
  localparam logic [11:0] ADDR_IRQ_ST_B      = 12'h026;
  localparam logic [11:0] ADDR_ERR_WINDOW    = 12'h034;
  localparam logic [11:0] ADDR_SNAP_ERROR    = 12'h038;
  localparam logic [11:0] ADDR_SNAP_FLAGS    = 12'h039;
  localparam logic [11:0] ADDR_SYNC_CONTROL  = 12'h03a;
  localparam logic [11:0] ADDR_SYNC_STATUS   = 12'h03b;
  localparam logic [11:0] ADDR_CUR_ERROR     = 12'h03c;
  localparam logic [11:0] ADDR_ERR_FLAGS     = 12'h03d;
  localparam logic [11:0] ADDR_SUBCLASS      = 12'h301;
  localparam logic [11:0] ADDR_LINK_DELAY0   = 12'h304;
  localparam logic [11:0] ADDR_LINK_DELAY1   = 12'h305;
  localparam logic [11:0] ADDR_DELAY_VAR0    = 12'h306;
  localparam logic [11:0] ADDR_DELAY_VAR1    = 12'h307;
  localparam logic [11:0] ADDR_SUBCLASS_LINK = 12'h458;
  // Control register fields.
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ARM_BIT    = 6;
  localparam int CTRL_CLEAR_BIT  = 5;
  // Status register fields.
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_ROT_BIT  = 2;
  localparam int STAT_WLIM_BIT = 1;
  localparam int STAT_TRIP_BIT = 0;
  // Interrupt event positions within the per-pair registers.
  localparam int EV_LOCK = 0;
  localparam int EV_ROT  = 1;
  localparam int EV_TRIP = 2;
  localparam int EV_WLIM = 3;
  // Error flag positions within the flag registers, and the subclass link field LSB.
  localparam int FLAG_LOW_BIT  = 7;
  localparam int FLAG_HIGH_BIT = 6;
  localparam int SUBLINK_LSB   = 5;
  // Sync mode codes.
  localparam logic [3:0] MODE_ONE_SHOT   = 4'h1;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
  localparam logic [3:0] MODE_MONITOR    = 4'h9;
  // Window code for half a DAC clock, subclass codes, limits.
  localparam logic [2:0] WINDOW_HALF   = 3'h0;
  localparam logic [2:0] SUBCLASS_0    = 3'h0;
  localparam logic [2:0] SUBCLASS_1    = 3'h1;
  localparam logic [7:0] RBD_MAX       = 8'h0a;
  localparam logic [2:0] OCTETS_PCLK   = 3'h4;
  localparam logic [2:0] OCTETS_ONE    = 3'h1;
  localparam logic [7:0] ROT_CYCLES    = 8'h04;
  localparam logic [7:0] DUAL_DEFAULT  = 8'h00;
endpackage
`default_nettype wire

// *** design/lmfc_sync.sv ***
// Behaviour
// - Monitor mode: align first edge, then only measure.
// - Mode field bits 3..0: 0x01, 0x02, 0x09.
// - Current error reads zero after alignment, else measured.
// - Out-of-window error sets low or high flag in monitor state.
// - Alignment snapshots last error and flags.
// - Window field selects half a clock, or one to seven clocks.
// - One-shot needs arm bit, then an alignment edge.
// - Status bit 7 shows busy, zero when done.
// - Each check updates lock and window-limit flags.
// - Sticky rotation flag on misaligned clock alignment.
// - Sticky trip flag per check; cleared by control.
// - Four status events per pair, enable and clear.
// - Only subclass 0 and 1 are accepted.
// - Subclass 0 aligns to internal processing clock.
// - No sync-pin error reporting, subclass 0, F=1.
// - Receive buffer delay limited to 0..10.
// - Each link has a delayed local multiframe clock.
// - Delay in frames; variation converted by 4/F.
// - One-shot checks first armed edge; aligns if outside.
// - Continuous checks every edge, ignores edges during rotation.
// - Alignment reference is active high, rising edge sampled.
// - Arm bit clears itself when an edge arrives.
`timescale 1ns/1ns
`default_nettype none
module lmfc_sync
  import lmfc_sync_pkg::*;
#(
  parameter int LMFC_PERIOD   = 64, // DAC clocks per multiframe.
  parameter int PCLK_DIV      = 16, // DAC clocks per processing clock.
  parameter int DAC_PER_FRAME = 4   // DAC clocks per frame clock.
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  input  wire logic        I_SYSREF,
  input  wire logic [2:0]  I_OCTETS_PER_FRAME,
  input  wire logic [11:0] I_REG_ADDR,
  input  wire logic        I_REG_WR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_REG_RD,
  output logic      [7:0]  O_REG_RDATA,
  output logic             O_REG_RVALID,
  output logic      [1:0]  O_LMFC_RX,
  output logic      [3:0]  O_RBD_LINK0,
  output logic      [3:0]  O_RBD_LINK1,
  output logic      [7:0]  O_VAR_FRAMES_LINK0,
  output logic      [7:0]  O_VAR_FRAMES_LINK1,
  output logic             O_SYNC_ERR_EN,
  output logic             O_IRQ
);
  localparam logic [7:0] PERIOD   = 8'(LMFC_PERIOD);
  localparam logic [7:0] HALF     = 8'(LMFC_PERIOD / 2);
  localparam logic [7:0] PCLK_TOP = 8'(PCLK_DIV - 1);

  // One-hot sync machine states.
  typedef enum logic [3:0] {
    ST_OFF     = 4'b0001,
    ST_WAIT    = 4'b0010,
    ST_ROTATE  = 4'b0100,
    ST_MONITOR = 4'b1000
  } sync_state_e;

  sync_state_e state;            // Sync machine state.
  logic [2:0]  sysref_sync;      // Synchroniser plus edge history.
  logic [7:0]  pclk_cnt;         // Internal processing clock divider.
  logic [7:0]  lmfc_cnt;         // Position within the multiframe.
  logic [7:0]  rot_cnt;          // Cycles left in a rotation.
  logic [7:0]  dual_sel;         // Which pairs take part.
  logic [3:0]  irq_en_a;         // Event enables, pair A.
  logic [3:0]  irq_en_b;         // Event enables, pair B.
  logic [3:0]  irq_st_a;         // Event status, pair A.
  logic [3:0]  irq_st_b;         // Event status, pair B.
  logic [2:0]  err_window;       // Window tolerance code.
  logic [7:0]  snap_err;         // Error copied at alignment.
  logic [1:0]  snap_flags;       // Flags copied at alignment.
  logic        sync_en;          // Machine enable.
  logic        sync_arm;         // Arm request, self clearing.
  logic [3:0]  sync_mode_select; // Processing mode.
  logic        lock_flag;        // Aligned at last check.
  logic        clock_rotation_flag;
  logic        window_limit_flag;
  logic        edge_trip_flag;
  logic [7:0]  cur_err;          // Current phase error magnitude.
  logic [1:0]  err_flags;        // Low and high side flags.
  logic [2:0]  subclass;         // Global subclass.
  logic [2:0]  subclass_link;    // Per-link subclass copy.
  logic [7:0]  link_delay_frames    [2]; // Local LMFC offsets.
  logic [7:0]  link_delay_variation [2]; // Buffer delays.

  // Decoded writes, alignment edge and phase measurement.
  logic       wr_ctrl, clr_sticky, align_edge, check, do_align;
  logic       err_high, err_low, exceed, busy;
  logic [7:0] err_mag;
  logic [7:0] tol;
  logic [3:0] events;

  assign wr_ctrl    = I_REG_WR && I_REG_ADDR == ADDR_SYNC_CONTROL;
  assign clr_sticky = wr_ctrl && I_REG_WDATA[CTRL_CLEAR_BIT];

  // Subclass 1 uses the reference pin rising edge, subclass 0 the
  // processing clock tick.
  assign align_edge = (subclass == SUBCLASS_1)
                    ? (sysref_sync[1] && !sysref_sync[2])
                    : (pclk_cnt == PCLK_TOP);

  // Positions past half a multiframe are early (low side).
  assign err_high = lmfc_cnt != 8'h00 && lmfc_cnt < HALF;
  assign err_low  = lmfc_cnt >= HALF;
  assign err_mag  = err_low ? 8'(PERIOD - lmfc_cnt) : lmfc_cnt;
  assign tol      = {5'h00, err_window};
  // Half a clock tolerance means any whole-clock error is out.
  assign exceed   = (err_window == WINDOW_HALF) ? (err_mag != 8'h00)
                                                : (err_mag > tol);

  // Edges arriving during a rotation are ignored.
  assign check = align_edge && (
      (state == ST_WAIT &&
       (sync_mode_select == MODE_CONTINUOUS || sync_arm)) ||
      state == ST_MONITOR);
  // Monitor state never rotates.
  assign do_align = check && state == ST_WAIT &&
      (sync_mode_select == MODE_MONITOR ? err_mag != 8'h00 : exceed);
  assign busy = state == ST_ROTATE || (state == ST_WAIT && sync_arm);

  // Event vector shared by both pairs.
  always_comb begin
    events          = 4'h0;
    events[EV_LOCK] = check && (do_align || err_mag == 8'h00);
    events[EV_ROT]  = do_align;
    events[EV_TRIP] = check;
    events[EV_WLIM] = check && !do_align && exceed;
  end

  // Pin synchroniser; only the second stage and later feed logic.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      sysref_sync <= 3'h0;
    end else begin
      sysref_sync <= {sysref_sync[1:0], I_SYSREF};
    end
  end

  // Internal processing clock used as the subclass 0 reference.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || pclk_cnt == PCLK_TOP) begin
      pclk_cnt <= 8'h00;
    end else begin
      pclk_cnt <= pclk_cnt + 8'h01;
    end
  end

  // Multiframe counter; an alignment restarts it at the edge.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || do_align) begin
      lmfc_cnt <= 8'h00;
    end else if (lmfc_cnt == 8'(PERIOD - 8'h01)) begin
      lmfc_cnt <= 8'h00;
    end else begin
      lmfc_cnt <= lmfc_cnt + 8'h01;
    end
  end

  // Sync machine. The rotation hold keeps the logic busy while the
  // clock phase settles, which is why later edges are not checked.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state   <= ST_OFF;
      rot_cnt <= 8'h00;
    end else if (!sync_en) begin
      state   <= ST_OFF;
      rot_cnt <= 8'h00;
    end else begin
      case (state)
        ST_OFF: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (do_align) begin
            state   <= ST_ROTATE;
            rot_cnt <= ROT_CYCLES - 8'h01;
          end else if (check && sync_mode_select == MODE_MONITOR) begin
            state <= ST_MONITOR;
          end
        end
        ST_ROTATE: begin
          if (rot_cnt == 8'h00) begin
            state <= (sync_mode_select == MODE_MONITOR) ? ST_MONITOR
                                                        : ST_WAIT;
          end else begin
            rot_cnt <= rot_cnt - 8'h01;
          end
        end
        ST_MONITOR: begin
          // Re-arming restarts the one-shot part of the mode.
          if (sync_arm && !align_edge) begin
            state <= ST_WAIT;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // Control register; the arm bit clears on any edge while enabled.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      sync_en          <= 1'b0;
      sync_arm         <= 1'b0;
      sync_mode_select <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        sync_en          <= I_REG_WDATA[CTRL_ENABLE_BIT];
        sync_mode_select <= I_REG_WDATA[3:0];
      end
      if (align_edge && sync_en) begin
        sync_arm <= 1'b0;
      end else if (wr_ctrl && I_REG_WDATA[CTRL_ARM_BIT]) begin
        sync_arm <= 1'b1;
      end
    end
  end

  // Phase report, snapshots and status flags.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      cur_err           <= 8'h00;
      err_flags         <= 2'h0;
      snap_err          <= 8'h00;
      snap_flags        <= 2'h0;
      lock_flag         <= 1'b0;
      window_limit_flag <= 1'b0;
    end else if (do_align) begin
      snap_err          <= cur_err;
      snap_flags        <= err_flags;
      cur_err           <= 8'h00;
      err_flags         <= 2'h0;
      lock_flag         <= 1'b1;
      window_limit_flag <= 1'b0;
    end else if (check) begin
      cur_err           <= err_mag;
      err_flags         <= {err_low && exceed, err_high && exceed};
      lock_flag         <= err_mag == 8'h00;
      window_limit_flag <= exceed;
    end
  end

  // Sticky flags; a new event wins over a clear.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      clock_rotation_flag <= 1'b0;
      edge_trip_flag      <= 1'b0;
    end else begin
      clock_rotation_flag <= do_align ||
                             (clock_rotation_flag && !clr_sticky);
      edge_trip_flag      <= check || (edge_trip_flag && !clr_sticky);
    end
  end

  // Configuration registers. A subclass above 1 is refused and the
  // old value is kept.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      dual_sel      <= DUAL_DEFAULT;
      irq_en_a      <= 4'h0;
      irq_en_b      <= 4'h0;
      err_window    <= WINDOW_HALF;
      subclass      <= SUBCLASS_0;
      subclass_link <= SUBCLASS_0;
    end else if (I_REG_WR) begin
      case (I_REG_ADDR)
        ADDR_DUAL_SELECT: dual_sel   <= I_REG_WDATA;
        ADDR_IRQ_EN_A:    irq_en_a   <= I_REG_WDATA[3:0];
        ADDR_IRQ_EN_B:    irq_en_b   <= I_REG_WDATA[3:0];
        ADDR_ERR_WINDOW:  err_window <= I_REG_WDATA[2:0];
        ADDR_SUBCLASS: begin
          if (I_REG_WDATA[2:0] <= SUBCLASS_1) begin
            subclass <= I_REG_WDATA[2:0];
          end
        end
        ADDR_SUBCLASS_LINK: begin
          if (I_REG_WDATA[7:SUBLINK_LSB] <= SUBCLASS_1) begin
            subclass_link <= I_REG_WDATA[7:SUBLINK_LSB];
          end
        end
        default: begin
          // Other addresses hold state elsewhere or nothing.
        end
      endcase
    end
  end

  // Per-pair interrupt status, write one to clear, set wins. Only
  // pairs chosen in the dual select register collect events.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      irq_st_a <= 4'h0;
      irq_st_b <= 4'h0;
    end else begin
      irq_st_a <= (dual_sel[0] ? events : 4'h0) |
                  (irq_st_a & ~((I_REG_WR && I_REG_ADDR == ADDR_IRQ_ST_A)
                               ? I_REG_WDATA[3:0] : 4'h0));
      irq_st_b <= (dual_sel[1] ? events : 4'h0) |
                  (irq_st_b & ~((I_REG_WR && I_REG_ADDR == ADDR_IRQ_ST_B)
                               ? I_REG_WDATA[3:0] : 4'h0));
    end
  end

  // Per-link delay registers and local multiframe clocks.
  for (genvar l = 0; l < 2; l++) begin : g_link
    logic [15:0] offset;  // Link offset in DAC clocks.
    logic [7:0]  factor;  // Frames per processing clock, 4/F.
    assign offset = 16'((16'(link_delay_frames[l]) *
                        16'(DAC_PER_FRAME)) % 16'(LMFC_PERIOD));
    assign factor = (I_OCTETS_PER_FRAME == 3'h0) ? 8'h00
                  : {5'h00, OCTETS_PCLK / I_OCTETS_PER_FRAME};

    // Writes to variation saturate at the buffer depth.
    always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
        link_delay_frames[l]    <= 8'h00;
        link_delay_variation[l] <= 8'h00;
      end else if (I_REG_WR) begin
        if (I_REG_ADDR == ADDR_LINK_DELAY0 + 12'(l)) begin
          link_delay_frames[l] <= I_REG_WDATA;
        end
        if (I_REG_ADDR == ADDR_DELAY_VAR0 + 12'(l)) begin
          link_delay_variation[l] <= (I_REG_WDATA > RBD_MAX)
                                   ? RBD_MAX : I_REG_WDATA;
        end
      end
    end

    // The local clock ticks the programmed distance after the
    // aligned one, so fixed link delay needs no longer period.
    always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
        O_LMFC_RX[l] <= 1'b0;
      end else begin
        O_LMFC_RX[l] <= {8'h00, lmfc_cnt} == offset;
      end
    end
  end

  // Buffer delay and frame conversion outputs.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_RBD_LINK0        <= 4'h0;
      O_RBD_LINK1        <= 4'h0;
      O_VAR_FRAMES_LINK0 <= 8'h00;
      O_VAR_FRAMES_LINK1 <= 8'h00;
    end else begin
      O_RBD_LINK0        <= link_delay_variation[0][3:0];
      O_RBD_LINK1        <= link_delay_variation[1][3:0];
      O_VAR_FRAMES_LINK0 <= 8'(link_delay_variation[0] * g_link[0].factor);
      O_VAR_FRAMES_LINK1 <= 8'(link_delay_variation[1] * g_link[1].factor);
    end
  end

  // Sync pin error reporting is off in subclass 0 with F of one.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_SYNC_ERR_EN <= 1'b0;
      O_IRQ         <= 1'b0;
    end else begin
      O_SYNC_ERR_EN <= !(subclass == SUBCLASS_0 &&
                         I_OCTETS_PER_FRAME == OCTETS_ONE);
      O_IRQ         <= |(irq_st_a & irq_en_a) |
                       |(irq_st_b & irq_en_b);
    end
  end

  // Read port: data one cycle after the strobe, zero if unmapped.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_REG_RDATA  <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      case (I_REG_ADDR)
        ADDR_DUAL_SELECT:  O_REG_RDATA <= dual_sel;
        ADDR_IRQ_EN_A:     O_REG_RDATA <= {4'h0, irq_en_a};
        ADDR_IRQ_EN_B:     O_REG_RDATA <= {4'h0, irq_en_b};
        ADDR_IRQ_ST_A:     O_REG_RDATA <= {4'h0, irq_st_a};
        ADDR_IRQ_ST_B:     O_REG_RDATA <= {4'h0, irq_st_b};
        ADDR_ERR_WINDOW:   O_REG_RDATA <= {5'h00, err_window};
        ADDR_SNAP_ERROR:   O_REG_RDATA <= snap_err;
        ADDR_SNAP_FLAGS:   O_REG_RDATA <= {snap_flags, 6'h00};
        ADDR_SYNC_CONTROL: O_REG_RDATA <= {sync_en, sync_arm, 2'h0,
                                           sync_mode_select};
        ADDR_SYNC_STATUS:  O_REG_RDATA <= {busy, 3'h0, lock_flag,
                                           clock_rotation_flag,
                                           window_limit_flag,
                                           edge_trip_flag};
        ADDR_CUR_ERROR:    O_REG_RDATA <= cur_err;
        ADDR_ERR_FLAGS:    O_REG_RDATA <= {err_flags, 6'h00};
        ADDR_SUBCLASS:     O_REG_RDATA <= {5'h00, subclass};
        ADDR_LINK_DELAY0:  O_REG_RDATA <= link_delay_frames[0];
        ADDR_LINK_DELAY1:  O_REG_RDATA <= link_delay_frames[1];
        ADDR_DELAY_VAR0:   O_REG_RDATA <= link_delay_variation[0];
        ADDR_DELAY_VAR1:   O_REG_RDATA <= link_delay_variation[1];
        ADDR_SUBCLASS_LINK: O_REG_RDATA <= {subclass_link, 5'h00};
        default:           O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Checks on the machine's own behaviour.
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  a_arm_self_clear: assert property (align_edge && sync_en |=> !sync_arm)
    else $error("arm bit did not clear after an edge");
  a_trip_sets: assert property (check |=> edge_trip_flag)
    else $error("trip flag missing after a check");
  a_trip_holds: assert property (edge_trip_flag && !clr_sticky
                                 |=> edge_trip_flag)
    else $error("trip flag dropped without a clear");
  a_align_zero_err: assert property (do_align |=> cur_err == 8'h00)
    else $error("current error not zero after alignment");
  a_snap_copy: assert property (do_align |=> snap_err == $past(cur_err))
    else $error("snapshot does not hold the last error");
  a_monitor_no_align: assert property (state == ST_MONITOR |-> !do_align)
    else $error("monitor state rotated the clock");
  a_rotate_busy: assert property (do_align |=>
                   (state == ST_ROTATE && busy)[*4] ##1 state != ST_ROTATE)
    else $error("rotation busy time wrong");
  a_ignore_busy: assert property (state == ST_ROTATE |-> !check)
    else $error("edge checked during rotation");
  a_window_flag: assert property (check && !do_align && exceed
                   |=> window_limit_flag && err_flags != 2'h0)
    else $error("window limit not reported");
  a_rot_sticky: assert property (do_align |=> clock_rotation_flag)
    else $error("rotation flag not set");
  a_rbd_limit: assert property (O_RBD_LINK0 <= RBD_MAX[3:0])
    else $error("buffer delay above limit");

  c_align: cover property (do_align ##[1:20] state == ST_WAIT);
  c_monitor_check: cover property (state == ST_MONITOR && check && exceed);
  c_continuous: cover property (check && sync_mode_select == MODE_CONTINUOUS
                                ##[1:200] check);
endmodule // lmfc_sync
`default_nettype wire

// *** sim/sysref_src.sv ***
`timescale 1ns/1ns
`default_nettype none
// Alignment source: a high pulse of i_len clocks per fire request.
module sysref_src (
  input  wire logic       i_clk,
  input  wire logic       i_fire,
  input  wire logic [3:0] i_len,
  output logic            o_sysref
);
  logic [3:0] left = 4'h0; // Clocks of high level still to go.
  // Launched just after an edge so the device samples it cleanly.
  always_ff @(posedge i_clk) begin
    if (i_fire) begin
      left <= i_len;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign o_sysref = (left != 4'h0);
endmodule // sysref_src
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lmfc_sync_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r;} row_s;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, fire = 0;
  logic [2:0] fpf = 3'h2;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, q, rdata, vf0, vf1;
  logic       sysref, rvalid, irq, err_en;
  logic [1:0] lmfc;
  logic [3:0] rbd0, rbd1;
  int         bad_count = 0, tests_run = 0, pulses = 0;
  // Write, then read back; read-only and unmapped places must not move.
  row_s rows [10] = '{
    '{ADDR_DUAL_SELECT, 8'h03, 8'h03},
    '{ADDR_ERR_WINDOW, 8'h03, 8'h03},
    '{ADDR_SUBCLASS, 8'h02, 8'h00},
    '{ADDR_SUBCLASS, 8'h01, 8'h01},
    '{ADDR_LINK_DELAY0, 8'h1a, 8'h1a},
    '{ADDR_DELAY_VAR0, 8'h0f, 8'h0a},
    '{ADDR_DELAY_VAR1, 8'h05, 8'h05},
    '{ADDR_IRQ_EN_A, 8'h0f, 8'h0f},
    '{ADDR_ERR_FLAGS, 8'hff, 8'h00},
    '{12'h100, 8'h55, 8'h00}};
  lmfc_sync DUT (.I_MCLK(clk), .I_RESET(rst), .I_SYSREF(sysref),
    .I_OCTETS_PER_FRAME(fpf), .I_REG_ADDR(addr), .I_REG_WR(wr),
    .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .O_LMFC_RX(lmfc), .O_RBD_LINK0(rbd0),
    .O_RBD_LINK1(rbd1), .O_VAR_FRAMES_LINK0(vf0),
    .O_VAR_FRAMES_LINK1(vf1), .O_SYNC_ERR_EN(err_en), .O_IRQ(irq));
  sysref_src src (.i_clk(clk), .i_fire(fire), .i_len(4'h4),
    .o_sysref(sysref));
  initial forever #20 clk = ~clk;
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  // Bounded wait, so a missing valid shows as a mismatch, not a hang.
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] m);
    int n;
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    q = rdata & m;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One reference pulse, then time for sync, check and rotation.
  task automatic send;
    @(negedge clk);
    fire = 1;
    @(negedge clk);
    fire = 0;
    repeat (14) @(negedge clk);
  endtask
  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    summarize;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a, 8'hff);
      chk(q, rows[i].r);
    end
    chk({4'h0, rbd0}, 8'h0a);
    chk({4'h0, rbd1}, 8'h05);
    chk(vf0, 8'h14);
    chk(vf1, 8'h0a);
    chk({7'h0, err_en}, 8'h01);
    fpf = 3'h1;
    wr_reg(ADDR_SUBCLASS, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h0, err_en}, 8'h00);
    fpf = 3'h2;
    wr_reg(ADDR_SUBCLASS, 8'h01);
    wr_reg(ADDR_SYNC_CONTROL, 8'h81);
    wr_reg(ADDR_SYNC_CONTROL, 8'hc1);
    rd_reg(ADDR_SYNC_STATUS, 8'h80);
    chk(q, 8'h80);
    send();
    rd_reg(ADDR_SYNC_CONTROL, 8'h40);
    chk(q, 8'h00);
    rd_reg(ADDR_CUR_ERROR, 8'hff);
    chk(q, 8'h00);
    rd_reg(ADDR_SYNC_STATUS, 8'h8d);
    chk(q, 8'h0d);
    rd_reg(ADDR_IRQ_ST_A, 8'h05);
    chk(q, 8'h05);
    chk({7'h0, irq}, 8'h01);
    wr_reg(ADDR_IRQ_ST_A, 8'h0f);
    wr_reg(ADDR_IRQ_ST_B, 8'h0f);
    chk({7'h0, irq}, 8'h00);
    wr_reg(ADDR_SYNC_CONTROL, 8'ha1);
    rd_reg(ADDR_SYNC_STATUS, 8'h05);
    chk(q, 8'h00);
    send();
    rd_reg(ADDR_SYNC_STATUS, 8'h01);
    chk(q, 8'h00);
    wr_reg(ADDR_SYNC_CONTROL, 8'h82);
    send();
    rd_reg(ADDR_SYNC_STATUS, 8'h01);
    chk(q, 8'h01);
    wr_reg(ADDR_SYNC_CONTROL, 8'ha9);
    wr_reg(ADDR_SYNC_CONTROL, 8'hc9);
    send();
    wr_reg(ADDR_SYNC_CONTROL, 8'ha9);
    send();
    // The monitored edge lands 17 clocks after the last alignment.
    rd_reg(ADDR_SYNC_STATUS, 8'h0f);
    chk(q, 8'h03);
    rd_reg(ADDR_CUR_ERROR, 8'hff);
    chk(q, 8'h11);
    rd_reg(ADDR_ERR_FLAGS, 8'hc0);
    chk(q, 8'h40);
    // Each local multiframe pulse comes once per multiframe.
    repeat (64) begin
      @(negedge clk);
      pulses += int'(lmfc[0]) + int'(lmfc[1]);
    end
    chk(8'(pulses), 8'h02);
    summarize;
  end
endmodule // tb
`default_nettype wire
